// ---- hdl/ssc_if.sv ----
// Pin bundle between the SRAM and its controller, with the shared data wire.
// Assumes both ends run on the same clock; the bench supplies nothing else.
`timescale 1ns/10ps
`default_nettype none
interface ssc_if #(
	parameter int AW = 10,
	parameter int DW = 32
);
	logic                chip_select_low;
	logic                processor_address_strobe_n;
	logic                controller_address_strobe_n;
	logic                burst_step_enable_n;
	logic                all_lanes_store_n;
	logic                lane_store_qualifier_n;
	logic [DW/8-1:0]     lane_store_selects_n;
	logic                output_enable_n;
	logic                sequence_order_select_n;
	logic                output_bypass_select_n;
	logic                sleep_request;
	logic [AW-1:0]       addr;
	logic [DW-1:0]       host_dq;
	logic                host_dq_oe_n;
	logic [DW-1:0]       dev_dq;
	logic                dev_dq_oe_n;
	wire  [DW-1:0]       dq;

	// Resolved data wire; a clash shows as the device value, an idle wire as zero
	assign dq = !dev_dq_oe_n ? dev_dq : (!host_dq_oe_n ? host_dq : {DW{1'b0}});

	modport device (
		input  chip_select_low, processor_address_strobe_n, controller_address_strobe_n,
		input  burst_step_enable_n, all_lanes_store_n, lane_store_qualifier_n,
		input  lane_store_selects_n, output_enable_n, sequence_order_select_n,
		input  output_bypass_select_n, sleep_request, addr, dq,
		output dev_dq, dev_dq_oe_n
	);
	modport host (
		output chip_select_low, processor_address_strobe_n, controller_address_strobe_n,
		output burst_step_enable_n, all_lanes_store_n, lane_store_qualifier_n,
		output lane_store_selects_n, output_enable_n, sequence_order_select_n,
		output output_bypass_select_n, sleep_request, addr, host_dq, host_dq_oe_n,
		input  dq
	);
endinterface
`default_nettype wire

// ---- hdl/ssc_pkg.sv ----
// Shared constants and types of the sync burst SRAM cycle control pair.
// Assumes one clock for both ends; controller registers sit on Avalon-MM.
package ssc_pkg;
	// Array and bus geometry
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int LANES  = DATA_W / 8;
	localparam int CNT_W  = 2;
	// Controller register word indices
	localparam int          AVS_AW     = 3;
	localparam logic [2:0] REG_CTRL   = 3'h0;
	localparam logic [2:0] REG_ADDR   = 3'h1;
	localparam logic [2:0] REG_WDATA  = 3'h2;
	localparam logic [2:0] REG_LANES  = 3'h3;
	localparam logic [2:0] REG_CMD    = 3'h4;
	localparam logic [2:0] REG_RDATA  = 3'h5;
	localparam logic [2:0] REG_STATUS = 3'h6;
	// Control register fields and reset value (pipeline, linear, awake)
	localparam int         CTRL_ORDER_BIT = 0;
	localparam int         CTRL_PIPE_BIT  = 1;
	localparam int         CTRL_SLEEP_BIT = 2;
	localparam int         CTRL_W         = 3;
	localparam logic [2:0] CTRL_RST       = 3'h2;
	// Command register fields
	localparam int CMD_KIND_LSB   = 0;
	localparam int CMD_KIND_W     = 3;
	localparam int CMD_WRITE_BIT  = 3;
	localparam int CMD_GLOBAL_BIT = 4;
	localparam int CMD_DUMMY_BIT  = 5;
	localparam int CMD_CS_OFF_BIT = 6;
	localparam int CMD_W          = 7;
	// Status register fields
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_RVALID_BIT = 1;
	// Cycles from the edge that launches the pins to the edge that takes read data
	localparam logic [1:0] LAT_FLOW = 2'h2;
	localparam logic [1:0] LAT_PIPE = 2'h3;
	localparam logic [1:0] LAT_NONE = 2'h1;

	// Kind of cycle the controller launches
	typedef enum logic [2:0] {
		SSC_K_DESEL, SSC_K_BEGIN_P, SSC_K_BEGIN_C, SSC_K_CONT, SSC_K_SUSP
	} ssc_kind_t;

	// Cycle decoded by the memory at a clock edge
	typedef enum logic [3:0] {
		SSC_C_IDLE, SSC_C_DESEL, SSC_C_READ_EXT, SSC_C_WRITE_EXT, SSC_C_READ_NEXT,
		SSC_C_WRITE_NEXT, SSC_C_READ_CUR, SSC_C_WRITE_CUR, SSC_C_SLEEP
	} ssc_cycle_t;
endpackage

// ---- hdl/ssc_sram_device.sv ----
// Synchronous burst SRAM end: cycle decode, 2-bit burst counter, array, output path.
// Assumes all controls are synchronous to clk_i except output_enable_n.
`timescale 1ns/10ps
`default_nettype none
module ssc_sram_device
	import ssc_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	input  wire logic   clk_i,
	input  wire logic   reset_i,
	ssc_if.device       bus,
	output ssc_cycle_t  cycle_o,
	output logic        asleep_o
);
	// Byte lanes on the data wire, one store select each
	localparam int LN = DW / 8;

	// Lane mask of a store; empty mask means the cycle is a read
	function automatic logic [LN-1:0] store_lanes(input logic all_n, input logic qual_n,
		input logic [LN-1:0] sel_n);
		logic [LN-1:0] m;
		m = '0;
		if (!all_n) begin
			m = '1;
		end else if (!qual_n) begin
			m = ~sel_n;
		end
		return m;
	endfunction

	// Low address bits for a burst step; interleave is an xor, linear a sum
	function automatic logic [CNT_W-1:0] burst_low(input logic [CNT_W-1:0] start,
		input logic [CNT_W-1:0] step, input logic interleave);
		logic [CNT_W-1:0] r;
		r = interleave ? (start ^ step) : CNT_W'(start + step);
		return r;
	endfunction

	// Read or write flavour of an access cycle, chosen by whether any lane is stored
	function automatic ssc_cycle_t rw_cycle(input logic store, input ssc_cycle_t wr_kind,
		input ssc_cycle_t rd_kind);
		return store ? wr_kind : rd_kind;
	endfunction

	logic [DW-1:0]    mem [2**AW];
	logic [AW-1:0]    base_q, base_d;
	logic [CNT_W-1:0] start_q, start_d;
	logic [CNT_W-1:0] step_q, step_d;
	logic [DW-1:0]    stage_q, stage_d;
	logic             stage_drv_q, stage_drv_d;
	logic [DW-1:0]    out_q, out_d;
	logic             out_drv_q, out_drv_d;
	ssc_cycle_t       cycle_q, cycle_d;
	logic             asleep_q, asleep_d;

	logic             sel;
	logic             interleave;
	logic             pipe;
	logic [LN-1:0]    lanes;
	logic             is_store;
	logic             access;
	logic             is_read;
	logic [AW-1:0]    acc_addr;
	logic [DW-1:0]    rd_word;

	// Static mode pins, and the chip select in active-high form
	assign interleave = bus.sequence_order_select_n;
	assign pipe       = bus.output_bypass_select_n;
	assign sel        = !bus.chip_select_low;

	// Cycle decode and burst counter; the order of the branches is the priority.
	// The counter keeps its start and a step count; the low address bits are
	// worked out from both, so the order pin may change between bursts.
	always_comb begin
		lanes    = store_lanes(bus.all_lanes_store_n, bus.lane_store_qualifier_n,
			bus.lane_store_selects_n);
		is_store = |lanes;
		base_d   = base_q;
		start_d  = start_q;
		step_d   = step_q;
		access   = 1'b0;
		acc_addr = {base_q[AW-1:CNT_W], burst_low(start_q, step_q, interleave)};
		cycle_d  = SSC_C_IDLE;
		if (bus.sleep_request) begin
			// Sleep ignores every synchronous control; contents are kept.
			// Sleep is taken as sampled at the edge here, not asynchronously.
			cycle_d = SSC_C_SLEEP;
		end else if (sel && !bus.processor_address_strobe_n) begin
			// Processor strobe decodes a read whatever the store inputs say, but set store lanes are still written
			base_d   = bus.addr;
			start_d  = bus.addr[CNT_W-1:0];
			step_d   = '0;
			acc_addr = bus.addr;
			access   = 1'b1;
			cycle_d  = SSC_C_READ_EXT;
		end else if (sel && !bus.controller_address_strobe_n) begin
			base_d   = bus.addr;
			start_d  = bus.addr[CNT_W-1:0];
			step_d   = '0;
			acc_addr = bus.addr;
			access   = 1'b1;
			cycle_d  = rw_cycle(is_store, SSC_C_WRITE_EXT, SSC_C_READ_EXT);
		end else if (!bus.controller_address_strobe_n) begin
			// Chip select off with controller strobe low uses no address
			cycle_d = SSC_C_DESEL;
		end else if (!bus.burst_step_enable_n) begin
			// Both strobes high, or deselected with processor strobe ignored
			step_d   = CNT_W'(step_q + 1'b1);
			acc_addr = {base_q[AW-1:CNT_W], burst_low(start_q, step_d, interleave)};
			access   = 1'b1;
			cycle_d  = rw_cycle(is_store, SSC_C_WRITE_NEXT, SSC_C_READ_NEXT);
		end else begin
			access  = 1'b1;
			cycle_d = rw_cycle(is_store, SSC_C_WRITE_CUR, SSC_C_READ_CUR);
		end
		// Output enable plays no part here, so dummy reads step alike
		is_read  = access && !is_store;
		asleep_d = bus.sleep_request;
	end

	// Array read at the address this edge will use
	assign rd_word = mem[acc_addr];

	// Output path: flow-through loads the output stage from the array directly.
	// Pipeline hands a read through one more register; a deselect right after
	// a read still lets that read out, while a store or sleep cuts it at once.
	always_comb begin
		stage_d     = is_read ? rd_word : stage_q;
		stage_drv_d = is_read;
		if (pipe) begin
			out_d     = stage_q;
			// Single cycle deselect: drivers fall one stage after the deselect
			out_drv_d = stage_drv_q && !(access && is_store)
				&& cycle_d != SSC_C_SLEEP;
		end else begin
			out_d     = is_read ? rd_word : out_q;
			out_drv_d = is_read;
		end
	end

	// Control state
	// Reset clears the counter, drivers, decoded cycle and sleep flag; the array keeps its words
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			base_q      <= '0;
			start_q     <= '0;
			step_q      <= '0;
			stage_drv_q <= 1'b0;
			out_drv_q   <= 1'b0;
			cycle_q     <= SSC_C_IDLE;
			asleep_q    <= 1'b0;
		end else begin
			base_q      <= base_d;
			start_q     <= start_d;
			step_q      <= step_d;
			stage_drv_q <= stage_drv_d;
			out_drv_q   <= out_drv_d;
			cycle_q     <= cycle_d;
			asleep_q    <= asleep_d;
		end
	end

	// Data registers need no reset; they are only seen while driving
	// Leaving them unreset keeps the wide data path free of reset fan-out
	always_ff @(posedge clk_i) begin
		stage_q <= stage_d;
		out_q   <= out_d;
	end

	// Lane writes; the store takes the data present at the same edge
	// One process owns the whole array, so no word has two writers
	always_ff @(posedge clk_i) begin
		for (int g = 0; g < LN; g++) begin
			if (!reset_i && access && lanes[g]) begin
				mem[acc_addr][8*g +: 8] <= bus.dq[8*g +: 8];
			end
		end
	end

	// Output enable is combined without a clock so that it acts at once
	// A flop here would keep drivers on for a clock after output enable rises
	assign bus.dev_dq      = out_q;
	assign bus.dev_dq_oe_n = bus.output_enable_n || !out_drv_q;

	assign cycle_o  = cycle_q;
	assign asleep_o = asleep_q;
endmodule
`default_nettype wire

// ---- hdl/ssc_sram_host.sv ----
// Controller end: Avalon-MM register slave that launches one SRAM cycle per command.
// Assumes the SRAM on the far side shares clk_i and follows the cycle truth table.
`timescale 1ns/10ps
`default_nettype none
module ssc_sram_host
	import ssc_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire logic [AVS_AW-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	output logic      [31:0]       avs_readdata_o,
	output logic                   avs_waitrequest_o,
	ssc_if.host                    bus
);
	localparam int LN = DW / 8;

	typedef enum logic [1:0] {SSC_ST_IDLE, SSC_ST_ISSUE, SSC_ST_WAIT} ssc_state_t;

	ssc_state_t      st_q, st_d;
	logic [1:0]      lat_q, lat_d;
	logic            take_q, take_d;
	logic [CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [AW-1:0]   addr_q, addr_d;
	logic [DW-1:0]   wdata_q, wdata_d;
	logic [LN-1:0]   lanes_q, lanes_d;
	logic [CMD_W-1:0] cmd_q, cmd_d;
	logic [DW-1:0]   rdata_q, rdata_d;
	logic            rvalid_q, rvalid_d;
	logic            wait_q, wait_d;
	logic [31:0]     rd_q, rd_d;
	// Pin registers: cs_n, processor_address_strobe_n, controller_address_strobe_n, adv_n, all_n, qual_n, oe_n, hdq_oe_n
	logic [7:0]      pin_q, pin_d;
	logic [LN-1:0]   sel_n_q, sel_n_d;

	logic            req;
	logic            blocked;
	logic            wr_now;
	ssc_kind_t       kind;
	logic            is_wr;
	// Idle pins form a deselect: select off, controller strobe low
	localparam logic [7:0] PIN_IDLE = 8'hfb;

	// Register slave; a new command waits while one is still in flight
	always_comb begin
		req     = avs_read_i || avs_write_i;
		blocked = avs_write_i && avs_address_i == REG_CMD && st_q != SSC_ST_IDLE;
		wait_d  = !(req && wait_q && !blocked);
		wr_now  = avs_write_i && !wait_q;
		ctrl_d  = ctrl_q;
		addr_d  = addr_q;
		wdata_d = wdata_q;
		lanes_d = lanes_q;
		cmd_d   = cmd_q;
		rd_d    = rd_q;
		if (wr_now) begin
			case (avs_address_i)
				REG_CTRL:  ctrl_d  = avs_writedata_i[CTRL_W-1:0];
				REG_ADDR:  addr_d  = avs_writedata_i[AW-1:0];
				REG_WDATA: wdata_d = avs_writedata_i[DW-1:0];
				REG_LANES: lanes_d = avs_writedata_i[LN-1:0];
				REG_CMD:   cmd_d   = avs_writedata_i[CMD_W-1:0];
				default:   ;
			endcase
		end
		if (req && wait_q && !blocked) begin
			case (avs_address_i)
				REG_CTRL:   rd_d = 32'(ctrl_q);
				REG_ADDR:   rd_d = 32'(addr_q);
				REG_WDATA:  rd_d = 32'(wdata_q);
				REG_LANES:  rd_d = 32'(lanes_q);
				REG_CMD:    rd_d = 32'(cmd_q);
				REG_RDATA:  rd_d = 32'(rdata_q);
				REG_STATUS: rd_d = 32'({rvalid_q, st_q != SSC_ST_IDLE});
				default:    rd_d = 32'h0000_0000;
			endcase
		end
	end

	// Cycle sequencer and pin drive
	always_comb begin
		kind     = ssc_kind_t'(avs_writedata_i[CMD_KIND_LSB +: CMD_KIND_W]);
		is_wr    = avs_writedata_i[CMD_WRITE_BIT];
		st_d     = st_q;
		lat_d    = lat_q;
		take_d   = take_q;
		rdata_d  = rdata_q;
		rvalid_d = rvalid_q;
		pin_d    = pin_q;
		sel_n_d  = sel_n_q;
		case (st_q)
			SSC_ST_IDLE: begin
				if (wr_now && avs_address_i == REG_CMD) begin
					rvalid_d = 1'b0;
					st_d     = SSC_ST_ISSUE;
					pin_d    = 8'hff;
					pin_d[0] = avs_writedata_i[CMD_CS_OFF_BIT];
					case (kind)
						SSC_K_DESEL:   begin pin_d[0] = 1'b1; pin_d[2] = 1'b0; end
						SSC_K_BEGIN_P: begin pin_d[0] = 1'b0; pin_d[1] = 1'b0; end
						SSC_K_BEGIN_C: begin pin_d[0] = 1'b0; pin_d[2] = 1'b0; end
						SSC_K_CONT:    pin_d[3] = 1'b0;
						default:       ;
					endcase
					// Processor strobe cycles always read, so no store is set up
					if (is_wr && kind != SSC_K_DESEL && kind != SSC_K_BEGIN_P) begin
						pin_d[4] = !avs_writedata_i[CMD_GLOBAL_BIT];
						pin_d[5] = 1'b0;
						pin_d[7] = 1'b0;
						sel_n_d  = ~lanes_q;
						lat_d    = LAT_NONE;
						take_d   = 1'b0;
					end else begin
						// A dummy read keeps output enable high so drivers stay off
						pin_d[6] = avs_writedata_i[CMD_DUMMY_BIT];
						lat_d    = kind == SSC_K_DESEL ? LAT_NONE :
							(ctrl_q[CTRL_PIPE_BIT] ? LAT_PIPE : LAT_FLOW);
						take_d   = kind != SSC_K_DESEL && !avs_writedata_i[CMD_DUMMY_BIT];
					end
				end
			end
			SSC_ST_ISSUE, SSC_ST_WAIT: begin
				// Pins fall back to deselect after one clock, output enable kept
				pin_d      = {pin_q[7] | 1'b1, pin_q[6], PIN_IDLE[5:0]};
				sel_n_d    = '1;
				st_d       = SSC_ST_WAIT;
				lat_d      = 2'(lat_q - 1'b1);
				if (lat_q == LAT_NONE) begin
					if (take_q) begin
						rdata_d  = bus.dq;
						rvalid_d = 1'b1;
					end
					pin_d = PIN_IDLE;
					st_d  = SSC_ST_IDLE;
				end
			end
			default: st_d = SSC_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_q     <= SSC_ST_IDLE;
			lat_q    <= LAT_NONE;
			take_q   <= 1'b0;
			ctrl_q   <= CTRL_RST;
			addr_q   <= '0;
			wdata_q  <= '0;
			lanes_q  <= '1;
			cmd_q    <= '0;
			rdata_q  <= '0;
			rvalid_q <= 1'b0;
			wait_q   <= 1'b1;
			rd_q     <= 32'h0000_0000;
			pin_q    <= PIN_IDLE;
			sel_n_q  <= '1;
		end else begin
			st_q     <= st_d;
			lat_q    <= lat_d;
			take_q   <= take_d;
			ctrl_q   <= ctrl_d;
			addr_q   <= addr_d;
			wdata_q  <= wdata_d;
			lanes_q  <= lanes_d;
			cmd_q    <= cmd_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
			wait_q   <= wait_d;
			rd_q     <= rd_d;
			pin_q    <= pin_d;
			sel_n_q  <= sel_n_d;
		end
	end

	// Pins straight from their registers
	assign bus.chip_select_low             = pin_q[0];
	assign bus.processor_address_strobe_n  = pin_q[1];
	assign bus.controller_address_strobe_n = pin_q[2];
	assign bus.burst_step_enable_n         = pin_q[3];
	assign bus.all_lanes_store_n           = pin_q[4];
	assign bus.lane_store_qualifier_n      = pin_q[5];
	assign bus.output_enable_n             = pin_q[6];
	assign bus.host_dq_oe_n                = pin_q[7];
	assign bus.lane_store_selects_n        = sel_n_q;
	assign bus.addr                        = addr_q;
	assign bus.host_dq                     = wdata_q;
	assign bus.sequence_order_select_n     = ctrl_q[CTRL_ORDER_BIT];
	assign bus.output_bypass_select_n      = ctrl_q[CTRL_PIPE_BIT];
	assign bus.sleep_request               = ctrl_q[CTRL_SLEEP_BIT];
	assign avs_readdata_o                  = rd_q;
	assign avs_waitrequest_o               = wait_q;
endmodule
`default_nettype wire

// ---- testbench/ssc_link_asserts.sv ----
// Checks on the SRAM link: cycle decode from the pins and data driver gating.
// Assumes one clock for both ends and sight of the memory's decoded cycle.
`timescale 1ns/10ps
`default_nettype none
module ssc_link_asserts
	import ssc_pkg::*;
#(
	parameter int DW = DATA_W
) (
	input wire logic		clk_i,
	input wire logic		reset_i,
	input wire logic		chip_select_low,
	input wire logic		processor_address_strobe_n,
	input wire logic		controller_address_strobe_n,
	input wire logic		burst_step_enable_n,
	input wire logic		all_lanes_store_n,
	input wire logic		lane_store_qualifier_n,
	input wire logic [DW/8-1:0]	lane_store_selects_n,
	input wire logic		output_enable_n,
	input wire logic		output_bypass_select_n,
	input wire logic		sleep_request,
	input wire logic		host_dq_oe_n,
	input wire logic		dev_dq_oe_n,
	input wire ssc_cycle_t		cycle_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic	wq;
	logic	go;
	logic	held;
	// Lane qualifier with every select high is a read, so no lane is stored
	assign wq = !all_lanes_store_n || (!lane_store_qualifier_n && !(&lane_store_selects_n));
	assign go = !sleep_request;
	// Neither strobe loads an address: burst step or suspend
	assign held = controller_address_strobe_n && (chip_select_low || processor_address_strobe_n);

	chk_desel_decode: assert property (
		go && chip_select_low && !controller_address_strobe_n |=> cycle_o == SSC_C_DESEL)
		else $error("deselect not decoded");
	chk_read_ext: assert property (
		go && !chip_select_low && !processor_address_strobe_n |=> cycle_o == SSC_C_READ_EXT)
		else $error("processor strobe read not decoded");
	chk_begin_ctrl: assert property (
		go && !chip_select_low && processor_address_strobe_n && !controller_address_strobe_n
		|=> cycle_o == ($past(wq) ? SSC_C_WRITE_EXT : SSC_C_READ_EXT))
		else $error("controller strobe begin wrong");
	chk_cont_next: assert property (
		go && held && !burst_step_enable_n
		|=> cycle_o == ($past(wq) ? SSC_C_WRITE_NEXT : SSC_C_READ_NEXT))
		else $error("burst continue wrong");
	chk_susp_cur: assert property (
		go && held && burst_step_enable_n
		|=> cycle_o == ($past(wq) ? SSC_C_WRITE_CUR : SSC_C_READ_CUR))
		else $error("burst suspend wrong");
	chk_oe_gate: assert property (output_enable_n |-> dev_dq_oe_n)
		else $error("drivers on with output enable high");
	chk_write_quiet: assert property (
		cycle_o inside {SSC_C_WRITE_EXT, SSC_C_WRITE_NEXT, SSC_C_WRITE_CUR} |-> dev_dq_oe_n)
		else $error("memory drives in a write");
	chk_read_drive: assert property (
		!output_bypass_select_n && !output_enable_n
		&& cycle_o inside {SSC_C_READ_EXT, SSC_C_READ_NEXT, SSC_C_READ_CUR} |-> !dev_dq_oe_n)
		else $error("flow read not driven");
	chk_no_clash: assert property (!host_dq_oe_n |-> dev_dq_oe_n)
		else $error("both ends drive data");
	// Main scenarios reached
	cover property (cycle_o == SSC_C_WRITE_NEXT);
	cover property (cycle_o == SSC_C_READ_CUR);
	cover property (cycle_o == SSC_C_READ_NEXT && output_enable_n);
	cover property (cycle_o == SSC_C_SLEEP);
endmodule
`default_nettype wire

// ---- testbench/sync_burst_sram_control_bench.sv ----
// Bench joining controller and memory: command table, then hand tests.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/10ps
`default_nettype none
module sync_burst_sram_control_bench
	import ssc_pkg::*;
;
	typedef struct packed {
		logic [2:0]	ctrl;
		logic [9:0]	addr;
		logic [31:0]	wdata;
		logic [3:0]	lanes;
		logic [6:0]	cmd;
		ssc_cycle_t	cyc;
		logic		rd;
		logic [31:0]	exp;
	} ssc_row_t;
	logic		clk_i = 1'b0;
	logic		reset_i = 1'b1;
	logic [2:0]	avs_address = 3'h0;
	logic		avs_read = 1'b0;
	logic		avs_write = 1'b0;
	logic [31:0]	avs_writedata = 32'h0;
	logic [31:0]	avs_readdata;
	logic		avs_waitrequest;
	ssc_cycle_t	cycle;
	logic		asleep;
	logic		clr = 1'b0;
	logic [15:0]	seen = 16'h0;
	int		failures = 0;
	int		checked = 0;
	int		ticks = 0;
	// Start 0x10 linear: 10,11,12,12,13 then wrap to 10
	ssc_row_t rows [20] = '{
		'{3'h2, 10'h010, 32'h11111111, 4'hf, 7'h1a, SSC_C_WRITE_EXT, 1'b0, 32'h0},
		'{3'h2, 10'h010, 32'h22222222, 4'hf, 7'h1b, SSC_C_WRITE_NEXT, 1'b0, 32'h0},
		'{3'h2, 10'h010, 32'h33333333, 4'hf, 7'h5b, SSC_C_WRITE_NEXT, 1'b0, 32'h0},
		'{3'h2, 10'h010, 32'h444444aa, 4'h1, 7'h0c, SSC_C_WRITE_CUR, 1'b0, 32'h0},
		'{3'h2, 10'h010, 32'h55555555, 4'hf, 7'h1b, SSC_C_WRITE_NEXT, 1'b0, 32'h0},
		'{3'h2, 10'h010, 32'h66666666, 4'hf, 7'h1b, SSC_C_WRITE_NEXT, 1'b0, 32'h0},
		'{3'h2, 10'h010, 32'h0, 4'hf, 7'h01, SSC_C_READ_EXT, 1'b1, 32'h66666666},
		'{3'h2, 10'h010, 32'h0, 4'hf, 7'h03, SSC_C_READ_NEXT, 1'b1, 32'h22222222},
		'{3'h2, 10'h010, 32'h0, 4'hf, 7'h04, SSC_C_READ_CUR, 1'b1, 32'h22222222},
		'{3'h0, 10'h012, 32'h0, 4'hf, 7'h02, SSC_C_READ_EXT, 1'b1, 32'h333333aa},
		'{3'h0, 10'h012, 32'h0, 4'hf, 7'h23, SSC_C_READ_NEXT, 1'b0, 32'h0},
		'{3'h0, 10'h012, 32'h0, 4'hf, 7'h03, SSC_C_READ_NEXT, 1'b1, 32'h66666666},
		'{3'h3, 10'h011, 32'h0, 4'hf, 7'h02, SSC_C_READ_EXT, 1'b1, 32'h22222222},
		'{3'h3, 10'h011, 32'h0, 4'hf, 7'h03, SSC_C_READ_NEXT, 1'b1, 32'h66666666},
		'{3'h3, 10'h011, 32'h0, 4'hf, 7'h03, SSC_C_READ_NEXT, 1'b1, 32'h55555555},
		'{3'h3, 10'h011, 32'h0, 4'hf, 7'h00, SSC_C_DESEL, 1'b0, 32'h0},
		'{3'h3, 10'h011, 32'h0, 4'hf, 7'h43, SSC_C_READ_NEXT, 1'b1, 32'h333333aa},
		'{3'h2, 10'h020, 32'h0, 4'hf, 7'h1a, SSC_C_WRITE_EXT, 1'b0, 32'h0},
		'{3'h2, 10'h020, 32'ha1b2c3d4, 4'h6, 7'h0a, SSC_C_WRITE_EXT, 1'b0, 32'h0},
		'{3'h1, 10'h020, 32'h0, 4'hf, 7'h02, SSC_C_READ_EXT, 1'b1, 32'h00b2c300}
	};

	ssc_if #(.AW(ADDR_W), .DW(DATA_W)) ssc_if_i ();
	ssc_sram_device #(.AW(ADDR_W), .DW(DATA_W)) ssc_sram_device_i (.clk_i(clk_i),
		.reset_i(reset_i), .bus(ssc_if_i.device), .cycle_o(cycle), .asleep_o(asleep));
	ssc_sram_host #(.AW(ADDR_W), .DW(DATA_W)) ssc_sram_host_i (.clk_i(clk_i),
		.reset_i(reset_i), .avs_address_i(avs_address), .avs_read_i(avs_read),
		.avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
		.avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
		.bus(ssc_if_i.host));
	ssc_link_asserts #(.DW(DATA_W)) ssc_link_asserts_i (.clk_i(clk_i), .reset_i(reset_i),
		.chip_select_low(ssc_if_i.chip_select_low),
		.processor_address_strobe_n(ssc_if_i.processor_address_strobe_n),
		.controller_address_strobe_n(ssc_if_i.controller_address_strobe_n),
		.burst_step_enable_n(ssc_if_i.burst_step_enable_n),
		.all_lanes_store_n(ssc_if_i.all_lanes_store_n),
		.lane_store_qualifier_n(ssc_if_i.lane_store_qualifier_n),
		.lane_store_selects_n(ssc_if_i.lane_store_selects_n),
		.output_enable_n(ssc_if_i.output_enable_n),
		.output_bypass_select_n(ssc_if_i.output_bypass_select_n),
		.sleep_request(ssc_if_i.sleep_request), .host_dq_oe_n(ssc_if_i.host_dq_oe_n),
		.dev_dq_oe_n(ssc_if_i.dev_dq_oe_n), .cycle_o(cycle));

	always #4 clk_i = !clk_i;

	// Every cycle kind decoded since the last clear
	always @(posedge clk_i) begin
		if (clr)
			seen <= 16'h0;
		else if (!reset_i)
			seen <= seen | (16'h1 << cycle);
	end

	// Run is about 600 cycles, so this ceiling only cuts a hang
	always @(posedge clk_i) begin
		ticks++;
		if (ticks == 20000) begin
			failures++;
			conclude();
		end
	end

	task automatic conclude();
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t data %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_cycle(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t cycle set %h expected %h", $time, got, exp);
		end
	endtask

	// Held request until waitrequest is seen low; data taken at that edge
	task automatic bus(input logic [2:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		if (n >= 64) begin
			failures++;
			$display("MISMATCH t=%0t no bus answer", $time);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(a, 1'b1, d, x);
	endtask

	task automatic rd(input logic [2:0] a, output logic [31:0] q);
		bus(a, 1'b0, 32'h0, q);
	endtask

	// Poll status until the sequencer is idle
	task automatic settle(output logic [31:0] st);
		st = 32'h1;
		for (int k = 0; k < 16 && st[STAT_BUSY_BIT] !== 1'b0; k++)
			rd(REG_STATUS, st);
	endtask

	// Issue a command, poll until idle; clears the cycle set first
	task automatic run_cmd(input logic [6:0] c, output logic [31:0] st);
		@(posedge clk_i);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		wr(REG_CMD, {25'h0, c});
		settle(st);
	endtask

	initial begin
		logic [31:0] q;
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		foreach (rows[i]) begin
			wr(REG_CTRL, {29'h0, rows[i].ctrl});
			wr(REG_ADDR, {22'h0, rows[i].addr});
			wr(REG_WDATA, rows[i].wdata);
			wr(REG_LANES, {28'h0, rows[i].lanes});
			run_cmd(rows[i].cmd, q);
			check_cycle(seen, (16'h1 << SSC_C_DESEL) | (16'h1 << rows[i].cyc));
			check_data({30'h0, q[1:0]}, {30'h0, rows[i].rd, 1'b0});
			if (rows[i].rd) begin
				rd(REG_RDATA, q);
				check_data(q, rows[i].exp);
			end
		end
		// Second command stalls while the first is in flight, then steps on
		wr(REG_CTRL, 32'h2);
		wr(REG_ADDR, 32'h10);
		wr(REG_CMD, 32'h1);
		wr(REG_CMD, 32'h3);
		settle(q);
		rd(REG_RDATA, q);
		check_data(q, 32'h22222222);
		// Reset in mid-run: registers return, memory keeps its words
		@(posedge clk_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check_data({31'h0, avs_waitrequest}, 32'h1);
		reset_i <= 1'b0;
		rd(REG_CTRL, q);
		check_data(q, {29'h0, CTRL_RST});
		rd(REG_LANES, q);
		check_data(q, 32'hf);
		wr(REG_ADDR, 32'h13);
		run_cmd(7'h01, q);
		rd(REG_RDATA, q);
		check_data(q, 32'h55555555);
		// Sleep: every cycle ignored, a store is dropped, contents kept
		wr(REG_CTRL, 32'h6);
		run_cmd(7'h1a, q);
		check_cycle(seen, 16'h1 << SSC_C_SLEEP);
		check_data({31'h0, asleep}, 32'h1);
		wr(REG_CTRL, 32'h2);
		run_cmd(7'h01, q);
		rd(REG_RDATA, q);
		check_data(q, 32'h55555555);
		// Unmapped index ignores writes and reads zero
		wr(3'h7, 32'hffffffff);
		rd(3'h7, q);
		check_data(q, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
